// ===== i2cbc_pkg.sv
// Shared constants and state type for the I2C collision-aware master
package i2cbc_pkg;
    localparam logic [3:0] ADDR_CTRL  = 4'h0;
    localparam logic [3:0] ADDR_STAT  = 4'h4;
    localparam logic [3:0] ADDR_DATA  = 4'h8;
    localparam logic [3:0] ADDR_BAUD  = 4'hc;
    localparam int CTL_EN   = 0;
    localparam int CTL_SEN  = 1;
    localparam int CTL_RSEN = 2;
    localparam int CTL_PEN  = 3;
    localparam int CTL_AKEN = 4;
    localparam int CTL_AKDT = 5;
    localparam int STS_BCL   = 0;
    localparam int STS_EVT   = 1;
    localparam int STS_BF    = 2;
    localparam int STS_START = 3;
    localparam int STS_STOP  = 4;
    localparam int STS_ACKST = 5;
    localparam int STS_BUSY  = 6;
    localparam int BAUD_W    = 7;
    localparam logic [6:0] BAUD_RST = 7'h04;
    localparam logic [3:0] LAST_BIT = 4'h8;
    typedef enum logic [4:0] {
        ST_IDLE, ST_A, ST_B,
        RS_A, RS_B, RS_C, RS_D,
        SP_A, SP_B, SP_C, SP_D,
        AK_A, AK_B, AK_C,
        TX_L, TX_W, TX_H
    } i2cbc_state_e;
endpackage : i2cbc_pkg

// ===== i2cbc_pin_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module i2cbc_pin_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic pinIn,
    output logic      level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;
    logic level_next;

    always_comb
    begin
        level_next = (s2_reg == s3_reg) ? s3_reg : level_reg;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s1_reg    <= RST_VAL;
            s2_reg    <= RST_VAL;
            s3_reg    <= RST_VAL;
            level_reg <= RST_VAL;
        end
        else
        begin
            s1_reg    <= pinIn;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            level_reg <= level_next;
        end
    end

    assign level = level_reg;
endmodule : i2cbc_pin_sync

// ===== i2cbc_master.sv
// I2C master sequencer with bus arbitration and collision recovery
// Contract
// - Released one read back low is collision
// - Collision sets flag, port returns idle
// - Collision during byte clears full, releases lines
// - Collision aborts sequence, clears its enable
// - After collision, bus STOP sets event flag
// - New buffer write starts at first bit
// - START with a line low is collision
// - START loads baud counter once SDA and SCL both high
// - SCL low during first START count collides
// - SDA low early drives SDA, no collision
// - Else SDA low, count, then SCL low
// - Repeated START: release, count, release SCL
// - SDA low at SCL rise is collision
// - SDA falling during count is harmless
// - SCL falling before own SDA low collides
// - Both high: SDA low, count, SCL low
// - STOP: SDA low, SCL release, count, check
// - SCL low before SDA release collides
// - Start and stop seen cleared when disabled
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module i2cbc_master (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [3:0]  avsAddress,
    input  wire logic        avsRead,
    input  wire logic        avsWrite,
    input  wire logic [31:0] avsWritedata,
    output logic [31:0]      avsReaddata,
    output logic             avsWaitrequest,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOe,
    input  wire logic        sclIn,
    output logic             sclOut,
    output logic             sclOe
);
    i2cbc_pkg::i2cbc_state_e state_reg, state_next;
    logic [6:0]  cnt_reg, cnt_next;
    logic [6:0]  baud_reg, baud_next;
    logic [7:0]  shift_reg, shift_next;
    logic [3:0]  bitCnt_reg, bitCnt_next;
    logic [5:0]  ctl_reg, ctl_next;
    logic        bf_reg, bf_next;
    logic        bcl_reg, bcl_next;
    logic        evt_reg, evt_next;
    logic        startSeen_reg, startSeen_next;
    logic        stopSeen_reg, stopSeen_next;
    logic        ackStat_reg, ackStat_next;
    logic        sdaDrv_reg, sdaDrv_next;
    logic        sclDrv_reg, sclDrv_next;
    logic        sdaPrev_reg;
    logic        ack_reg;
    logic [31:0] rdata_reg, rdata_next;
    logic        sdaS;
    logic        sclS;
    logic        tick;
    logic        load;
    logic        collide;
    logic        wrAcc;
    logic        txBit;
    logic        busStart;
    logic        busStop;

    i2cbc_pin_sync #(.RST_VAL(1'b1)) uSdaSync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pinIn   (sdaIn),
        .level   (sdaS)
    );

    i2cbc_pin_sync #(.RST_VAL(1'b1)) uSclSync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pinIn   (sclIn),
        .level   (sclS)
    );

    // One wait state per access keeps read data registered
    assign avsWaitrequest = (avsRead | avsWrite) & ~ack_reg;
    assign avsReaddata    = rdata_reg;
    assign wrAcc          = avsWrite & ack_reg;
    assign tick           = (cnt_reg == 7'h00);
    assign txBit          = (bitCnt_reg < i2cbc_pkg::LAST_BIT) ? shift_reg[7] : 1'b1;
    assign busStart       = sclS & sdaPrev_reg & ~sdaS;
    assign busStop        = sclS & ~sdaPrev_reg & sdaS;
    // Open-drain: only ever pull low
    assign sdaOut         = 1'b0;
    assign sclOut         = 1'b0;
    assign sdaOe          = sdaDrv_reg;
    assign sclOe          = sclDrv_reg;

    always_comb
    begin
        rdata_next = rdata_reg;
        if (avsRead && !ack_reg)
        begin
            rdata_next = 32'h0000_0000;
            if (avsAddress == i2cbc_pkg::ADDR_CTRL)
                rdata_next[5:0] = ctl_reg;
            else if (avsAddress == i2cbc_pkg::ADDR_STAT)
                rdata_next[6:0] = {state_reg != i2cbc_pkg::ST_IDLE, ackStat_reg,
                                   stopSeen_reg, startSeen_reg, bf_reg, evt_reg, bcl_reg};
            else if (avsAddress == i2cbc_pkg::ADDR_DATA)
                rdata_next[7:0] = shift_reg;
            else if (avsAddress == i2cbc_pkg::ADDR_BAUD)
                rdata_next[6:0] = baud_reg;
        end
    end

    always_comb
    begin
        state_next     = state_reg;
        cnt_next       = tick ? cnt_reg : cnt_reg - 7'h01;
        baud_next      = baud_reg;
        shift_next     = shift_reg;
        bitCnt_next    = bitCnt_reg;
        ctl_next       = ctl_reg;
        bf_next        = bf_reg;
        bcl_next       = bcl_reg;
        evt_next       = evt_reg;
        startSeen_next = startSeen_reg;
        stopSeen_next  = stopSeen_reg;
        ackStat_next   = ackStat_reg;
        sdaDrv_next    = sdaDrv_reg;
        sclDrv_next    = sclDrv_reg;
        load           = 1'b0;
        collide        = 1'b0;

        // Software side first, so hardware sets below win over clears
        if (wrAcc && avsAddress == i2cbc_pkg::ADDR_CTRL)
            ctl_next = avsWritedata[5:0];
        if (wrAcc && avsAddress == i2cbc_pkg::ADDR_BAUD)
            baud_next = avsWritedata[6:0];
        if (wrAcc && avsAddress == i2cbc_pkg::ADDR_STAT)
        begin
            if (avsWritedata[i2cbc_pkg::STS_BCL])
                bcl_next = 1'b0;
            if (avsWritedata[i2cbc_pkg::STS_EVT])
                evt_next = 1'b0;
        end
        // Writes while busy are dropped; after a collision the port is idle again
        if (wrAcc && avsAddress == i2cbc_pkg::ADDR_DATA && state_reg == i2cbc_pkg::ST_IDLE
            && ctl_reg[i2cbc_pkg::CTL_EN])
        begin
            shift_next  = avsWritedata[7:0];
            bitCnt_next = 4'h0;
            bf_next     = 1'b1;
            sclDrv_next = 1'b1;
            load        = 1'b1;
            state_next  = i2cbc_pkg::TX_L;
        end

        if (busStart)
        begin
            startSeen_next = 1'b1;
            stopSeen_next  = 1'b0;
        end
        if (busStop)
        begin
            stopSeen_next  = 1'b1;
            startSeen_next = 1'b0;
            evt_next       = 1'b1;
        end

        case (state_reg)
            i2cbc_pkg::ST_IDLE:
            begin
                if (ctl_reg[i2cbc_pkg::CTL_EN] && ctl_reg[i2cbc_pkg::CTL_SEN])
                begin
                    if (!sdaS || !sclS)
                        collide = 1'b1;
                    else
                    begin
                        load       = 1'b1;
                        state_next = i2cbc_pkg::ST_A;
                    end
                end
                else if (ctl_reg[i2cbc_pkg::CTL_EN] && ctl_reg[i2cbc_pkg::CTL_RSEN])
                begin
                    sdaDrv_next = 1'b0;
                    load        = 1'b1;
                    state_next  = i2cbc_pkg::RS_A;
                end
                else if (ctl_reg[i2cbc_pkg::CTL_EN] && ctl_reg[i2cbc_pkg::CTL_PEN])
                begin
                    sdaDrv_next = 1'b1;
                    state_next  = i2cbc_pkg::SP_A;
                end
                else if (ctl_reg[i2cbc_pkg::CTL_EN] && ctl_reg[i2cbc_pkg::CTL_AKEN])
                begin
                    sclDrv_next = 1'b1;
                    sdaDrv_next = ~ctl_reg[i2cbc_pkg::CTL_AKDT];
                    load        = 1'b1;
                    state_next  = i2cbc_pkg::AK_A;
                end
            end
            i2cbc_pkg::ST_A:
            begin
                if (!sdaS)
                begin
                    sdaDrv_next = 1'b1;
                    load        = 1'b1;
                    state_next  = i2cbc_pkg::ST_B;
                end
                else if (!sclS)
                    collide = 1'b1;
                else if (tick)
                begin
                    sdaDrv_next = 1'b1;
                    load        = 1'b1;
                    state_next  = i2cbc_pkg::ST_B;
                end
            end
            i2cbc_pkg::ST_B:
            begin
                // SCL is ignored here: a rival START loses on the address
                if (tick)
                begin
                    sclDrv_next                 = 1'b1;
                    ctl_next[i2cbc_pkg::CTL_SEN] = 1'b0;
                    evt_next                    = 1'b1;
                    state_next                  = i2cbc_pkg::ST_IDLE;
                end
            end
            i2cbc_pkg::RS_A:
            begin
                if (tick)
                begin
                    sclDrv_next = 1'b0;
                    state_next  = i2cbc_pkg::RS_B;
                end
            end
            i2cbc_pkg::RS_B:
            begin
                if (sclS && !sdaS)
                    collide = 1'b1;
                else if (sclS)
                begin
                    load       = 1'b1;
                    state_next = i2cbc_pkg::RS_C;
                end
            end
            i2cbc_pkg::RS_C:
            begin
                if (!sclS && sdaS)
                    collide = 1'b1;
                else if (tick)
                begin
                    sdaDrv_next = 1'b1;
                    load        = 1'b1;
                    state_next  = i2cbc_pkg::RS_D;
                end
            end
            i2cbc_pkg::RS_D:
            begin
                if (tick)
                begin
                    sclDrv_next                  = 1'b1;
                    ctl_next[i2cbc_pkg::CTL_RSEN] = 1'b0;
                    evt_next                     = 1'b1;
                    state_next                   = i2cbc_pkg::ST_IDLE;
                end
            end
            i2cbc_pkg::SP_A:
            begin
                if (!sdaS)
                begin
                    sclDrv_next = 1'b0;
                    state_next  = i2cbc_pkg::SP_B;
                end
            end
            i2cbc_pkg::SP_B:
            begin
                if (sclS)
                begin
                    load       = 1'b1;
                    state_next = i2cbc_pkg::SP_C;
                end
            end
            i2cbc_pkg::SP_C:
            begin
                if (!sclS)
                    collide = 1'b1;
                else if (tick)
                begin
                    sdaDrv_next = 1'b0;
                    load        = 1'b1;
                    state_next  = i2cbc_pkg::SP_D;
                end
            end
            i2cbc_pkg::SP_D:
            begin
                if (tick && !sdaS)
                    collide = 1'b1;
                else if (tick)
                begin
                    ctl_next[i2cbc_pkg::CTL_PEN] = 1'b0;
                    evt_next                    = 1'b1;
                    state_next                  = i2cbc_pkg::ST_IDLE;
                end
            end
            i2cbc_pkg::AK_A:
            begin
                if (tick)
                begin
                    sclDrv_next = 1'b0;
                    state_next  = i2cbc_pkg::AK_B;
                end
            end
            i2cbc_pkg::AK_B:
            begin
                if (sclS)
                begin
                    load       = 1'b1;
                    state_next = i2cbc_pkg::AK_C;
                end
            end
            i2cbc_pkg::AK_C:
            begin
                if (!sdaDrv_reg && !sdaS)
                    collide = 1'b1;
                else if (tick)
                begin
                    sclDrv_next                   = 1'b1;
                    sdaDrv_next                   = 1'b0;
                    ctl_next[i2cbc_pkg::CTL_AKEN] = 1'b0;
                    state_next                    = i2cbc_pkg::ST_IDLE;
                end
            end
            i2cbc_pkg::TX_L:
            begin
                sdaDrv_next = ~txBit;
                if (tick)
                begin
                    sclDrv_next = 1'b0;
                    state_next  = i2cbc_pkg::TX_W;
                end
            end
            i2cbc_pkg::TX_W:
            begin
                if (sclS)
                begin
                    load       = 1'b1;
                    state_next = i2cbc_pkg::TX_H;
                end
            end
            i2cbc_pkg::TX_H:
            begin
                if (bitCnt_reg < i2cbc_pkg::LAST_BIT && txBit && !sdaS)
                    collide = 1'b1;
                else if (tick)
                begin
                    sclDrv_next = 1'b1;
                    load        = 1'b1;
                    if (bitCnt_reg == i2cbc_pkg::LAST_BIT)
                    begin
                        ackStat_next = sdaS;
                        evt_next     = 1'b1;
                        state_next   = i2cbc_pkg::ST_IDLE;
                    end
                    else
                    begin
                        shift_next  = {shift_reg[6:0], 1'b0};
                        bitCnt_next = bitCnt_reg + 4'h1;
                        if (bitCnt_reg == i2cbc_pkg::LAST_BIT - 4'h1)
                            bf_next = 1'b0;
                        state_next = i2cbc_pkg::TX_L;
                    end
                end
            end
            default:
                state_next = i2cbc_pkg::ST_IDLE;
        endcase

        if (load)
            cnt_next = baud_reg;

        if (collide)
        begin
            bcl_next    = 1'b1;
            state_next  = i2cbc_pkg::ST_IDLE;
            bf_next     = 1'b0;
            sdaDrv_next = 1'b0;
            sclDrv_next = 1'b0;
            ctl_next[i2cbc_pkg::CTL_AKEN:i2cbc_pkg::CTL_SEN] = 4'h0;
        end

        if (!ctl_reg[i2cbc_pkg::CTL_EN])
        begin
            state_next     = i2cbc_pkg::ST_IDLE;
            sdaDrv_next    = 1'b0;
            sclDrv_next    = 1'b0;
            bf_next        = 1'b0;
            startSeen_next = 1'b0;
            stopSeen_next  = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg     <= i2cbc_pkg::ST_IDLE;
            cnt_reg       <= 7'h00;
            baud_reg      <= i2cbc_pkg::BAUD_RST;
            shift_reg     <= 8'h00;
            bitCnt_reg    <= 4'h0;
            ctl_reg       <= 6'h00;
            bf_reg        <= 1'b0;
            bcl_reg       <= 1'b0;
            evt_reg       <= 1'b0;
            startSeen_reg <= 1'b0;
            stopSeen_reg  <= 1'b0;
            ackStat_reg   <= 1'b0;
            sdaDrv_reg    <= 1'b0;
            sclDrv_reg    <= 1'b0;
            sdaPrev_reg   <= 1'b1;
            ack_reg       <= 1'b0;
            rdata_reg     <= 32'h0000_0000;
        end
        else
        begin
            state_reg     <= state_next;
            cnt_reg       <= cnt_next;
            baud_reg      <= baud_next;
            shift_reg     <= shift_next;
            bitCnt_reg    <= bitCnt_next;
            ctl_reg       <= ctl_next;
            bf_reg        <= bf_next;
            bcl_reg       <= bcl_next;
            evt_reg       <= evt_next;
            startSeen_reg <= startSeen_next;
            stopSeen_reg  <= stopSeen_next;
            ackStat_reg   <= ackStat_next;
            sdaDrv_reg    <= sdaDrv_next;
            sclDrv_reg    <= sclDrv_next;
            sdaPrev_reg   <= sdaS;
            ack_reg       <= (avsRead | avsWrite) & ~ack_reg;
            rdata_reg     <= rdata_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence collHit;
        collide && ctl_reg[i2cbc_pkg::CTL_EN];
    endsequence
    sequence portReleased;
        state_reg == i2cbc_pkg::ST_IDLE && !sdaOe && !sclOe;
    endsequence
    sequence startRun;
        state_reg == i2cbc_pkg::ST_A && sdaS && sclS && tick;
    endsequence

    coll_idle_a: assert property (collHit |=> portReleased)
        else $error("collision did not release port");
    coll_bf_a: assert property (collHit |=> !bf_reg && bcl_reg)
        else $error("collision left buffer full");
    coll_seq_a: assert property (collHit |=> ctl_reg[4:1] == 4'h0)
        else $error("collision left sequence enabled");
    bcl_sticky_a: assert property (bcl_reg
        && !(wrAcc && avsAddress == i2cbc_pkg::ADDR_STAT) |=> bcl_reg)
        else $error("collision flag cleared by itself");
    stop_evt_a: assert property (busStop && ctl_reg[i2cbc_pkg::CTL_EN] |=> evt_reg)
        else $error("bus stop missed event flag");
    tx_first_a: assert property (state_reg == i2cbc_pkg::ST_IDLE
        && state_next == i2cbc_pkg::TX_L |=> bitCnt_reg == 4'h0 && bf_reg)
        else $error("transmit did not restart at first bit");
    tx_coll_a: assert property (state_reg == i2cbc_pkg::TX_H && bitCnt_reg < 4'h8
        && txBit && !sdaS && ctl_reg[i2cbc_pkg::CTL_EN] |=> bcl_reg)
        else $error("lost arbitration not flagged");
    start_busy_a: assert property (state_reg == i2cbc_pkg::ST_IDLE
        && ctl_reg[1:0] == 2'h3 && !(sdaS && sclS) |=> bcl_reg && !sdaOe)
        else $error("start on busy bus not flagged");
    // SCL must still be free when SDA goes low; a zero reload ends the count at once
    start_seq_a: assert property (startRun
        |=> sdaOe && !sclOe && cnt_reg == baud_reg ##1 (sclOe == (baud_reg == 7'h00)))
        else $error("start sequence order wrong");
    start_early_a: assert property (state_reg == i2cbc_pkg::ST_A
        && !sdaS && ctl_reg[i2cbc_pkg::CTL_EN] |=> sdaOe && state_reg == i2cbc_pkg::ST_B)
        else $error("early SDA low not followed");
    rs_sda_a: assert property (state_reg == i2cbc_pkg::RS_B
        && sclS && !sdaS && ctl_reg[i2cbc_pkg::CTL_EN] |=> bcl_reg)
        else $error("repeated start SDA low missed");
    stop_scl_a: assert property (state_reg == i2cbc_pkg::SP_C
        && !sclS && ctl_reg[i2cbc_pkg::CTL_EN] |=> bcl_reg && !sdaOe)
        else $error("stop SCL low missed");
    dis_clear_a: assert property (!ctl_reg[i2cbc_pkg::CTL_EN]
        |=> !startSeen_reg && !stopSeen_reg)
        else $error("start or stop seen while disabled");
endmodule : i2cbc_master

// ===== i2cbc_far_end.sv
// Open-drain I2C bus with pull-ups and a far-side master that can pull lines
`timescale 1ns/1ps
module i2cbc_far_end (
    input  wire logic sdaOe,
    input  wire logic sclOe,
    input  wire logic pullSda,
    input  wire logic pullScl,
    output logic      sdaLine,
    output logic      sclLine
);
    // Wired-AND; a released line goes to the pull-up level
    assign sdaLine = ~(sdaOe | pullSda);
    assign sclLine = ~(sclOe | pullScl);
endmodule : i2cbc_far_end

// ===== test_i2c_master_bus_collision.sv
// Self-checking bench for bus arbitration and collision recovery
`timescale 1ns/1ps
module test_i2c_master_bus_collision;
    logic        clk;
    logic        sys_rst;
    logic [3:0]  avsAddress;
    logic        avsRead;
    logic        avsWrite;
    logic [31:0] avsWritedata;
    logic [31:0] avsReaddata;
    logic        avsWaitrequest;
    logic        sdaOe;
    logic        sclOe;
    logic        sdaLine;
    logic        sclLine;
    logic        pullSda;
    logic        pullScl;
    logic [31:0] rdVal;
    int          err_count = 0;
    int          tests_run = 0;
    int          cycles = 0;

    i2cbc_master u_dut (.clk(clk), .sys_rst(sys_rst), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
        .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .sdaIn(sdaLine),
        .sdaOut(), .sdaOe(sdaOe), .sclIn(sclLine), .sclOut(), .sclOe(sclOe));
    i2cbc_far_end u_far (.sdaOe(sdaOe), .sclOe(sclOe), .pullSda(pullSda),
        .pullScl(pullScl), .sdaLine(sdaLine), .sclLine(sclLine));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out

    // One Avalon access; request held until waitrequest is seen low
    task automatic acc(input logic [3:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        avsAddress <= a;
        avsWritedata <= d;
        avsWrite <= w;
        avsRead <= ~w;
        // Sampled at the rising edge, before that edge updates it
        do
            @(posedge clk);
        while (avsWaitrequest !== 1'b0);
        rdVal = avsReaddata;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask : acc

    // Polls a register bit; the value read is left in rdVal
    task automatic waitBit(input logic [3:0] a, input int b, input logic want);
        int n;
        n = 0;
        do
        begin
            acc(a, 1'b0, 32'h0);
            n++;
        end
        while (rdVal[b] !== want && n < 100);
    endtask : waitBit

    task automatic lines(input string what, input logic s, input logic c);
        @(negedge clk);
        chk(what, {30'h0, sdaOe, sclOe}, {30'h0, s, c});
        @(posedge clk);
    endtask : lines

    task automatic startOk();
        acc(4'h0, 1'b1, 32'h03);
        waitBit(4'h0, 1, 1'b0);
        chk("start done", rdVal, 32'h01);
        acc(4'h4, 1'b0, 32'h0);
        chk("start bcl", 32'(rdVal[0]), 32'h0);
    endtask : startOk

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Whole run is well under this many cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            err_count++;
            close_out();
        end
    end

    initial
    begin
        sys_rst = 1'b1;
        {avsAddress, avsRead, avsWrite, avsWritedata, pullSda, pullScl} = '0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            acc(4'(i * 4 + (i / 4) * 2), 1'b0, 32'h0);
            chk("reset", rdVal, (i == 3) ? 32'h04 : 32'h0);
        end
        // Reload of four or more leaves room for the pin sync on STOP
        acc(4'hc, 1'b1, 32'h05);
        acc(4'h0, 1'b1, 32'h01);
        pullSda <= 1'b1;
        repeat (8) @(posedge clk);
        acc(4'h0, 1'b1, 32'h03);
        waitBit(4'h4, 0, 1'b1);
        chk("bcl start", 32'(rdVal[0]), 32'h1);
        acc(4'h0, 1'b0, 32'h0);
        chk("ctrl start", rdVal, 32'h01);
        lines("lines start", 1'b0, 1'b0);
        // Far master ends its transfer: SDA rises while SCL high
        acc(4'h4, 1'b1, 32'h02);
        repeat (13) @(posedge clk);
        pullSda <= 1'b0;
        waitBit(4'h4, 1, 1'b1);
        chk("event", 32'(rdVal[1]), 32'h1);
        chk("stop seen", 32'(rdVal[4]), 32'h1);
        chk("bcl held", 32'(rdVal[0]), 32'h1);
        acc(4'h4, 1'b1, 32'h03);
        acc(4'h4, 1'b0, 32'h0);
        chk("bcl w1c", 32'(rdVal[0]), 32'h0);
        // Bus free with stop seen, so a new START is allowed
        startOk();
        lines("lines held", 1'b1, 1'b1);
        pullSda <= 1'b1;
        acc(4'h8, 1'b1, 32'h3f);
        waitBit(4'h4, 0, 1'b1);
        chk("bcl tx", 32'(rdVal[0]), 32'h1);
        chk("bf tx", 32'(rdVal[2]), 32'h0);
        lines("lines tx", 1'b0, 1'b0);
        pullSda <= 1'b0;
        acc(4'h4, 1'b1, 32'h03);
        // Leading zero of a fresh byte shows only if shifting restarts
        acc(4'h8, 1'b1, 32'h3f);
        for (int i = 0; i < 20 && sdaOe !== 1'b1; i++)
            @(negedge clk);
        chk("first bit", 32'(sdaOe), 32'h1);
        acc(4'h4, 1'b0, 32'h0);
        chk("bf again", 32'(rdVal[2]), 32'h1);
        acc(4'h0, 1'b1, 32'h0);
        acc(4'h4, 1'b0, 32'h0);
        chk("seen off", 32'(rdVal[4:3]), 32'h0);
        acc(4'h0, 1'b1, 32'h01);
        startOk();
        acc(4'h0, 1'b1, 32'h05);
        for (int i = 0; i < 50 && sclOe !== 1'b0; i++)
            @(negedge clk);
        // Stretch SCL so SDA is surely low at its rise
        @(posedge clk);
        pullScl <= 1'b1;
        pullSda <= 1'b1;
        repeat (8) @(posedge clk);
        pullScl <= 1'b0;
        waitBit(4'h4, 0, 1'b1);
        chk("bcl rstart", 32'(rdVal[0]), 32'h1);
        acc(4'h0, 1'b0, 32'h0);
        chk("ctrl rstart", rdVal, 32'h01);
        pullSda <= 1'b0;
        acc(4'h4, 1'b1, 32'h03);
        startOk();
        acc(4'h0, 1'b1, 32'h09);
        waitBit(4'h0, 3, 1'b0);
        chk("ctrl stop", rdVal, 32'h01);
        acc(4'h4, 1'b0, 32'h0);
        chk("stop ok", 32'(rdVal[4]), 32'h1);
        chk("bcl stop", 32'(rdVal[0]), 32'h0);
        lines("lines stop", 1'b0, 1'b0);
        // Rival pulls SCL low while our STOP counts with SCL released
        startOk();
        acc(4'h0, 1'b1, 32'h09);
        for (int i = 0; i < 50 && sclOe !== 1'b0; i++)
            @(negedge clk);
        repeat (4) @(posedge clk);
        pullScl <= 1'b1;
        waitBit(4'h4, 0, 1'b1);
        chk("bcl stop scl", 32'(rdVal[0]), 32'h1);
        acc(4'h0, 1'b0, 32'h0);
        chk("ctrl stop scl", rdVal, 32'h01);
        lines("lines stop scl", 1'b0, 1'b0);
        pullScl <= 1'b0;
        close_out();
    end
endmodule : test_i2c_master_bus_collision
